// ===== verilog/pwm_brake_mode_control.sv
// How it works
// - Polarity 0: low brake pin asserts brake.
// - Polarity 1: high brake pin asserts brake.
// - No brake starts while enable is 0.
// - Prescale field divides clock by 1,2,4,16.
// - Prescaler phase-aligned while generator runs.
// - Mode field picks edge, single-shot, centre counting.
// - Software brake forces outputs to brake levels.
// - Software brake keeps generator and run bit.
// - Release shows current generator output at once.
// - Stop brake forces levels while run is 0.
// - Stop brake applies nothing while run is 1.
// - Stop brake release restores stopped generator state.
// - Pin brake forces levels and clears run.
// - Pin brake sets the brake flag.
// - Pin brake ends after pin release and enable clear.
// - Flag-only pin brake sets flag, generator runs.
// - Flag-only pin brake leaves outputs normal.
// - Channel 4 compare low byte is read/write.
`timescale 1ns/10ps
`include "pwm_brake_params.svh"

module pwm_brake_mode_control #(
  parameter int NCH = 6,
  parameter int CW = 12,
  parameter int AW = 12
) (
  // Clock, reset and clock enable.
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clkEn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // Brake sources.
  input wire logic brakeInputPin,
  input wire logic smartBrakeDetect,
  // Compare values of the channels other than channel 4.
  input wire logic [NCH*CW-1:0] otherCompare,
  // PWM outputs.
  output logic [NCH-1:0] pwmOut
);

  localparam int CH4 = 4;

  ////////////////////////////////////////////////////////////////////////////
  // Functions.

  function automatic logic [7:0] regIdx(input logic [AW-1:0] addr);
    regIdx = addr[9:2];
  endfunction

  function automatic logic [3:0] divLast(input logic [1:0] sel);
    unique case (sel)
      `PRESCALE_DIV1: divLast = `DIV_LAST_1;
      `PRESCALE_DIV2: divLast = `DIV_LAST_2;
      `PRESCALE_DIV4: divLast = `DIV_LAST_4;
      `PRESCALE_DIV16: divLast = `DIV_LAST_16;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Registers and state.

  pwm_brake_pkg::brake_mode_t brakeMode_reg;
  pwm_brake_pkg::ahb_req_t req_reg;
  pwm_brake_pkg::count_dir_t dir_reg;
  logic [7:0] cmpLow_reg;
  logic [CW-9:0] cmpHigh_reg;
  logic [NCH-1:0] brakeLevel_reg;
  logic [CW-1:0] period_reg;
  logic [CW-1:0] cnt_reg;
  logic [3:0] preCnt_reg;
  logic generatorRun_reg;
  logic smartDetectSelect_reg;
  logic brakeFlag_reg;
  logic pinBrake_reg;
  logic shotDone_reg;
  logic wrPend_reg;
  logic rdWait_reg;
  logic [31:0] hrdata_reg;
  logic [NCH-1:0] pwmOut_reg;
  logic pinSync1_reg;
  logic pinSync2_reg;
  logic pinSync3_reg;
  logic pinStable_reg;

  logic accept;
  logic wrCommit;
  logic [7:0] wrIdx;
  logic brakeAsserted;
  logic softBrake;
  logic stopBrake;
  logic pinBrakeSet;
  logic flagSet;
  logic forceActive;
  logic tick;
  logic shotEnd;
  logic [NCH-1:0] genOut;
  logic [NCH*CW-1:0] compareAll;
  logic [31:0] readWord;

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: writes without wait, reads with one wait state.

  assign accept = hsel & htrans[1] & hready & clkEn;
  assign wrCommit = wrPend_reg & clkEn;
  assign wrIdx = req_reg.idx;
  assign hreadyout = ~rdWait_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      req_reg <= '0;
      wrPend_reg <= 1'b0;
    end else if (clkEn) begin
      wrPend_reg <= accept & hwrite;
      if (accept) begin
        req_reg.idx <= regIdx(haddr);
        req_reg.write <= hwrite;
      end
    end
  end

  // Read data is taken one cycle after the address so that a write in
  // the previous data phase is already stored.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rdWait_reg <= 1'b0;
      hrdata_reg <= 32'h00000000;
    end else if (clkEn) begin
      if (rdWait_reg) begin
        rdWait_reg <= 1'b0;
        hrdata_reg <= readWord;
      end else begin
        rdWait_reg <= accept & ~hwrite;
      end
    end
  end

  always_comb begin
    readWord = 32'h00000000;
    unique case (req_reg.idx)
      `IDX_BRAKE_MODE: readWord[7:0] = brakeMode_reg;
      `IDX_CH4_CMP_LOW: readWord[7:0] = cmpLow_reg;
      `IDX_GEN_CTRL: begin
        readWord[`CTRL_RUN_BIT] = generatorRun_reg;
        readWord[`CTRL_SMART_BIT] = smartDetectSelect_reg;
        readWord[`CTRL_FLAG_BIT] = brakeFlag_reg;
      end
      `IDX_BRAKE_LEVEL: readWord[NCH-1:0] = brakeLevel_reg;
      `IDX_PERIOD_LOW: readWord[7:0] = period_reg[7:0];
      `IDX_PERIOD_HIGH: readWord[CW-9:0] = period_reg[CW-1:8];
      `IDX_CH4_CMP_HIGH: readWord[CW-9:0] = cmpHigh_reg;
      `IDX_STATUS: begin
        readWord[0] = pinBrake_reg;
        readWord[1] = forceActive;
        readWord[2] = pinStable_reg;
        readWord[3] = (dir_reg == pwm_brake_pkg::DIR_DOWN);
        readWord[4] = shotDone_reg;
      end
      default: readWord = 32'h00000000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers.

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      brakeMode_reg <= `RST_BRAKE_MODE;
    end else if (wrCommit && wrIdx == `IDX_BRAKE_MODE) begin
      brakeMode_reg.brakeModeHigh <= hwdata[7];
      brakeMode_reg.brakePolaritySelect <= hwdata[6];
      brakeMode_reg.brakePinEnable <= hwdata[5];
      brakeMode_reg.brakeEnable <= hwdata[4];
      brakeMode_reg.prescaleSelect <= hwdata[3:2];
      if (hwdata[1:0] != `MODE_RESERVED) begin
        brakeMode_reg.counterModeSelect <= hwdata[1:0];
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmpLow_reg <= `RST_CH4_CMP_LOW;
      cmpHigh_reg <= `RST_CH4_CMP_HIGH;
      brakeLevel_reg <= '0;
      period_reg <= {`RST_PERIOD_HIGH, `RST_PERIOD_LOW};
      smartDetectSelect_reg <= 1'b0;
    end else if (wrCommit) begin
      if (wrIdx == `IDX_CH4_CMP_LOW) cmpLow_reg <= hwdata[7:0];
      if (wrIdx == `IDX_CH4_CMP_HIGH) cmpHigh_reg <= hwdata[CW-9:0];
      if (wrIdx == `IDX_BRAKE_LEVEL) brakeLevel_reg <= hwdata[NCH-1:0];
      if (wrIdx == `IDX_PERIOD_LOW) period_reg[7:0] <= hwdata[7:0];
      if (wrIdx == `IDX_PERIOD_HIGH) period_reg[CW-1:8] <= hwdata[CW-9:0];
      if (wrIdx == `IDX_GEN_CTRL) begin
        smartDetectSelect_reg <= hwdata[`CTRL_SMART_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brake pin synchroniser: a change counts once stages two and three agree.

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pinSync1_reg <= 1'b0;
      pinSync2_reg <= 1'b0;
      pinSync3_reg <= 1'b0;
      pinStable_reg <= 1'b0;
    end else if (clkEn) begin
      pinSync1_reg <= brakeInputPin;
      pinSync2_reg <= pinSync1_reg;
      pinSync3_reg <= pinSync2_reg;
      if (pinSync2_reg == pinSync3_reg) pinStable_reg <= pinSync3_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Brake conditions.

  assign brakeAsserted = smartDetectSelect_reg ? smartBrakeDetect :
    brakeMode_reg.brakePolaritySelect ? pinStable_reg :
    ~pinStable_reg;

  // Every condition is gated by the brake enable bit.
  assign softBrake = brakeMode_reg.brakeEnable &
    ~brakeMode_reg.brakePinEnable & ~brakeMode_reg.brakeModeHigh;
  assign stopBrake = brakeMode_reg.brakeEnable &
    ~brakeMode_reg.brakePinEnable & brakeMode_reg.brakeModeHigh &
    ~generatorRun_reg;
  assign pinBrakeSet = brakeMode_reg.brakeEnable &
    brakeMode_reg.brakePinEnable & ~brakeMode_reg.brakeModeHigh &
    brakeAsserted;
  assign flagSet = brakeMode_reg.brakeEnable &
    brakeMode_reg.brakePinEnable & brakeAsserted;
  assign forceActive = softBrake | stopBrake | pinBrake_reg;

  // The pin brake holds until the pin is released and enable is cleared.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pinBrake_reg <= 1'b0;
    end else if (clkEn) begin
      if (pinBrakeSet) begin
        pinBrake_reg <= 1'b1;
      end else if (!brakeAsserted && !brakeMode_reg.brakeEnable) begin
        pinBrake_reg <= 1'b0;
      end
    end
  end

  // Brake flag: write one to clear, a new brake event wins.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      brakeFlag_reg <= 1'b0;
    end else if (clkEn) begin
      if (flagSet) begin
        brakeFlag_reg <= 1'b1;
      end else if (wrCommit && wrIdx == `IDX_GEN_CTRL &&
                   hwdata[`CTRL_FLAG_BIT]) begin
        brakeFlag_reg <= 1'b0;
      end
    end
  end

  // Run bit: hardware stops for a pin brake or a finished single shot.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      generatorRun_reg <= 1'b0;
    end else if (clkEn) begin
      if (pinBrakeSet || pinBrake_reg || shotEnd) begin
        generatorRun_reg <= 1'b0;
      end else if (wrCommit && wrIdx == `IDX_GEN_CTRL) begin
        generatorRun_reg <= hwdata[`CTRL_RUN_BIT];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Prescaler: held at zero while stopped so that it starts in phase.

  assign tick = generatorRun_reg &
    (preCnt_reg == divLast(brakeMode_reg.prescaleSelect));

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      preCnt_reg <= 4'h0;
    end else if (clkEn) begin
      if (!generatorRun_reg || tick) begin
        preCnt_reg <= 4'h0;
      end else begin
        preCnt_reg <= preCnt_reg + 4'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter. It keeps running through a software brake.

  assign shotEnd = tick &
    (brakeMode_reg.counterModeSelect == `MODE_SHOT) &
    (cnt_reg == period_reg);

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt_reg <= '0;
      dir_reg <= pwm_brake_pkg::DIR_UP;
      shotDone_reg <= 1'b0;
    end else if (clkEn) begin
      if (shotDone_reg && generatorRun_reg) begin
        cnt_reg <= '0;
        shotDone_reg <= 1'b0;
      end else if (tick) begin
        unique case (brakeMode_reg.counterModeSelect)
          `MODE_EDGE: begin
            dir_reg <= pwm_brake_pkg::DIR_UP;
            if (cnt_reg == period_reg) begin
              cnt_reg <= '0;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
          `MODE_SHOT: begin
            dir_reg <= pwm_brake_pkg::DIR_UP;
            if (cnt_reg == period_reg) begin
              shotDone_reg <= 1'b1;
            end else begin
              cnt_reg <= cnt_reg + 1'b1;
            end
          end
          `MODE_CENTRE: begin
            if (dir_reg == pwm_brake_pkg::DIR_UP) begin
              if (cnt_reg == period_reg) begin
                dir_reg <= pwm_brake_pkg::DIR_DOWN;
                cnt_reg <= cnt_reg - 1'b1;
              end else begin
                cnt_reg <= cnt_reg + 1'b1;
              end
            end else begin
              if (cnt_reg == '0) begin
                dir_reg <= pwm_brake_pkg::DIR_UP;
                cnt_reg <= cnt_reg + 1'b1;
              end else begin
                cnt_reg <= cnt_reg - 1'b1;
              end
            end
          end
          default: cnt_reg <= cnt_reg;
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Generator compare and output stage.

  always_comb begin
    compareAll = otherCompare;
    compareAll[CH4*CW +: CW] = {cmpHigh_reg, cmpLow_reg};
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      genOut[i] = (cnt_reg < compareAll[i*CW +: CW]);
    end
  end

  // A stopped generator holds its count, so its held state reappears once
  // a stop or pin brake is released.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pwmOut_reg <= '0;
    end else if (clkEn) begin
      if (forceActive) begin
        pwmOut_reg <= brakeLevel_reg;
      end else begin
        pwmOut_reg <= genOut;
      end
    end
  end

  assign pwmOut = pwmOut_reg;

endmodule

// ===== verilog/pwm_brake_params.svh
`ifndef PWM_BRAKE_PARAMS_SVH
`define PWM_BRAKE_PARAMS_SVH
`define IDX_BRAKE_MODE 8'hCE
`define IDX_CH4_CMP_LOW 8'hCF
`define IDX_GEN_CTRL 8'hC0
`define IDX_BRAKE_LEVEL 8'hC1
`define IDX_PERIOD_LOW 8'hC2
`define IDX_PERIOD_HIGH 8'hC3
`define IDX_CH4_CMP_HIGH 8'hC4
`define IDX_STATUS 8'hC5
`define RST_BRAKE_MODE 8'h00
`define RST_CH4_CMP_LOW 8'h00
`define RST_BRAKE_LEVEL 8'h00
`define RST_PERIOD_LOW 8'hFF
`define RST_PERIOD_HIGH 4'hF
`define RST_CH4_CMP_HIGH 4'h0
`define CTRL_RUN_BIT 0
`define CTRL_SMART_BIT 1
`define CTRL_FLAG_BIT 2
`define PRESCALE_DIV1 2'h0
`define PRESCALE_DIV2 2'h1
`define PRESCALE_DIV4 2'h2
`define PRESCALE_DIV16 2'h3
`define DIV_LAST_1 4'h0
`define DIV_LAST_2 4'h1
`define DIV_LAST_4 4'h3
`define DIV_LAST_16 4'hF
`define MODE_EDGE 2'h0
`define MODE_SHOT 2'h1
`define MODE_CENTRE 2'h2
`define MODE_RESERVED 2'h3
`endif

// ===== verilog/pwm_brake_pkg.sv
package pwm_brake_pkg;

  // Field layout of the brake and mode control register, bit 7 first.
  typedef struct packed {
    logic brakeModeHigh;
    logic brakePolaritySelect;
    logic brakePinEnable;
    logic brakeEnable;
    logic [1:0] prescaleSelect;
    logic [1:0] counterModeSelect;
  } brake_mode_t;

  // One accepted bus request, held for its data phase.
  typedef struct packed {
    logic [7:0] idx;
    logic write;
  } ahb_req_t;

  typedef enum logic {
    DIR_UP,
    DIR_DOWN
  } count_dir_t;

endpackage

// ===== sim/pwm_brake_mode_control_properties.sv
`timescale 1ns/10ps
`include "pwm_brake_params.svh"
module pwm_brake_checker #(
  parameter int NCH = 6,
  parameter int AW = 12
) (
  // Clock, reset and clock enable.
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clkEn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  // Brake sources and outputs.
  input wire logic brakeInputPin,
  input wire logic smartBrakeDetect,
  input wire logic [NCH-1:0] pwmOut
);
  pwm_brake_pkg::brake_mode_t modeSh;
  logic [7:0] cmpSh;
  logic [7:0] wrIdx;
  logic [NCH-1:0] lvlSh;
  logic smartSh, wrPend, take, rdTake, pinOn, swBrake, pinBrake;

  assign take = hsel && htrans[1] && hready && clkEn;
  assign rdTake = take && !hwrite;
  assign pinOn = smartSh ? smartBrakeDetect :
    (modeSh.brakePolaritySelect ? brakeInputPin : !brakeInputPin);
  assign swBrake = modeSh.brakeEnable && !modeSh.brakePinEnable &&
    !modeSh.brakeModeHigh;
  assign pinBrake = pinOn && modeSh.brakeEnable &&
    modeSh.brakePinEnable && !modeSh.brakeModeHigh;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wrPend <= 1'b0;
      wrIdx <= 8'h00;
    end else if (clkEn) begin
      wrPend <= take && hwrite;
      wrIdx <= haddr[9:2];
    end
  end

  // Shadow copies of the registers the properties depend on.
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      modeSh <= '0;
      cmpSh <= 8'h00;
      lvlSh <= '0;
      smartSh <= 1'b0;
    end else if (clkEn && wrPend) begin
      if (wrIdx == `IDX_BRAKE_MODE) begin
        modeSh <= (hwdata[1:0] == `MODE_RESERVED) ?
          {hwdata[7:2], modeSh.counterModeSelect} : hwdata[7:0];
      end
      if (wrIdx == `IDX_CH4_CMP_LOW) cmpSh <= hwdata[7:0];
      if (wrIdx == `IDX_BRAKE_LEVEL) lvlSh <= hwdata[NCH-1:0];
      if (wrIdx == `IDX_GEN_CTRL) smartSh <= hwdata[`CTRL_SMART_BIT];
    end
  end

  ////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  okay_resp_a: assert property (hresp == 1'b0)
    else $error("bus response not OKAY");
  write_no_wait_a: assert property (take && hwrite |=> hreadyout)
    else $error("write inserted a wait state");
  read_wait_a: assert property (rdTake |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  ready_idle_a: assert property (!rdTake |=> hreadyout)
    else $error("ready low without a read");
  mode_read_a: assert property (
    rdTake && haddr[9:2] == `IDX_BRAKE_MODE |-> ##2 hrdata == {24'h0, modeSh})
    else $error("mode register read back wrong");
  cmp_read_a: assert property (
    rdTake && haddr[9:2] == `IDX_CH4_CMP_LOW |-> ##2 hrdata == {24'h0, cmpSh})
    else $error("compare low byte read back wrong");
  sw_brake_a: assert property (
    (swBrake && $stable(lvlSh))[*3] |-> pwmOut == lvlSh)
    else $error("software brake levels not driven");
  pin_brake_a: assert property (
    (pinBrake && clkEn)[*8] |-> pwmOut == lvlSh)
    else $error("pin brake levels not driven");

  cover property (pinBrake [*8]);
  cover property (swBrake [*3]);
  cover property (rdTake && haddr[9:2] == `IDX_BRAKE_MODE);
endmodule

bind pwm_brake_mode_control pwm_brake_checker #(.NCH(NCH), .AW(AW)) u_chk (
  .clk_sys(clk_sys), .rstn(rstn), .clkEn(clkEn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .brakeInputPin(brakeInputPin), .smartBrakeDetect(smartBrakeDetect),
  .pwmOut(pwmOut));

// ===== sim/power_stage_model.sv
`timescale 1ns/10ps
module power_stage_model (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rstn,
  // Gate drive and fault request.
  input wire logic [5:0] pwmOut,
  input wire logic fault,
  input wire logic activeHigh,
  // Fault line and pulse measurement of channel 0.
  output logic brakeInputPin,
  output logic [15:0] width,
  output logic [15:0] falls
);
  logic [15:0] cnt;

  assign brakeInputPin = fault ? activeHigh : !activeHigh;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cnt <= 16'h0;
      width <= 16'h0;
      falls <= 16'h0;
    end else if (pwmOut[0]) begin
      cnt <= cnt + 16'h1;
    end else if (cnt != 16'h0) begin
      width <= cnt;
      falls <= falls + 16'h1;
      cnt <= 16'h0;
    end
  end
endmodule

// ===== sim/pwm_brake_mode_control_tb.sv
`timescale 1ns/10ps
`include "pwm_brake_params.svh"
module pwm_brake_mode_control_tb;
  logic clk_sys, rstn, hwrite, pin, fault, high, smart, rdPhase;
  logic hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [31:0] hwdata, hrdata;
  logic [71:0] cmp;
  logic [5:0] pwmOut;
  logic [15:0] lfsrReg, width, falls, n0;
  logic [31:0] expQ[$];
  int n_mismatch, n_tests;

  pwm_brake_mode_control u_dut (.clk_sys(clk_sys), .rstn(rstn),
    .clkEn(1'b1), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .brakeInputPin(pin), .smartBrakeDetect(smart), .otherCompare(cmp),
    .pwmOut(pwmOut));
  power_stage_model u_stage (.clk_sys(clk_sys), .rstn(rstn),
    .pwmOut(pwmOut), .fault(fault), .activeHigh(high),
    .brakeInputPin(pin), .width(width), .falls(falls));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  ////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic end_sim;
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic waitRdy;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys);
      if (hreadyout === 1'b1) break;
    end
    if (i == 50) begin
      n_mismatch++;
      end_sim();
    end
  endtask

  task automatic bus(input logic w, input logic [7:0] idx,
                     input logic [31:0] d);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {2'h0, idx, 2'h0};
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
  endtask

  task automatic wr(input logic [7:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [31:0] e);
    expQ.push_back(e);
    bus(1'b0, idx, 32'h0);
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk_sys);
  endtask

  // Read data is compared when the data phase completes.
  always @(posedge clk_sys) begin
    if (rdPhase && hreadyout === 1'b1) begin
      rdPhase = 1'b0;
      if (expQ.size() == 0) begin
        n_mismatch++;
        $display("BAD t=%0t got=%h exp=%h", $time, hrdata, 32'h0);
      end else begin
        check(hrdata, expQ.pop_front());
      end
    end
    if (htrans[1] && hreadyout === 1'b1 && !hwrite) rdPhase = 1'b1;
  end

  initial begin
    {rstn, hwrite, fault, high, smart, rdPhase} = '0;
    {haddr, htrans, hwdata, cmp} = '0;
    n_mismatch = 0;
    n_tests = 0;
    lfsrReg = 16'h0A11;
    for (int i = 0; i < 5; i++) begin
      lfsrReg = lfsr(lfsrReg);
      cmp = {cmp[55:0], lfsrReg};
    end
    cmp[11:0] = 12'h002;
    repeat (16) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    rd(`IDX_BRAKE_MODE, 32'h0);
    rd(8'h10, 32'h0);
    wr(`IDX_CH4_CMP_LOW, {lfsrReg, lfsrReg});
    rd(`IDX_CH4_CMP_LOW, {24'h0, lfsrReg[7:0]});
    for (int m = 0; m < 4; m++) begin
      wr(`IDX_BRAKE_MODE, 32'(m * 5));
      rd(`IDX_BRAKE_MODE, m == 3 ? 32'hE : 32'(m * 5));
    end
    wr(`IDX_PERIOD_LOW, 32'h5);
    wr(`IDX_PERIOD_HIGH, 32'h0);
    wr(`IDX_GEN_CTRL, 32'h1);
    for (int p = 0; p < 4; p++) begin
      wr(`IDX_BRAKE_MODE, 32'(p * 4));
      wt(200);
      check({16'h0, width}, p == 3 ? 32'h20 : 32'(2 << p));
    end
    wr(`IDX_BRAKE_MODE, 32'h1);
    wt(30);
    rd(`IDX_GEN_CTRL, 32'h0);
    wr(`IDX_BRAKE_MODE, 32'h0);
    wr(`IDX_GEN_CTRL, 32'h1);
    wr(`IDX_BRAKE_LEVEL, 32'h2A);
    wr(`IDX_BRAKE_MODE, 32'h10);
    wt(4);
    check({26'h0, pwmOut}, 32'h2A);
    rd(`IDX_GEN_CTRL, 32'h1);
    wr(`IDX_BRAKE_MODE, 32'h0);
    n0 = falls;
    wt(20);
    check({31'h0, falls != n0}, 32'h1);
    wr(`IDX_BRAKE_MODE, 32'h20);
    fault <= 1'b1;
    wt(20);
    rd(`IDX_GEN_CTRL, 32'h1);
    fault <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      high <= (k == 1);
      wr(`IDX_GEN_CTRL, {30'h0, k == 2, 1'b1});
      wr(`IDX_BRAKE_MODE, k == 1 ? 32'h70 : 32'h30);
      fault <= (k < 2);
      smart <= (k == 2);
      wt(10);
      check({26'h0, pwmOut}, 32'h2A);
      rd(`IDX_GEN_CTRL, k == 2 ? 32'h6 : 32'h4);
      fault <= 1'b0;
      smart <= 1'b0;
      wt(10);
      check({26'h0, pwmOut}, 32'h2A);
      wr(`IDX_BRAKE_MODE, 32'h0);
      wr(`IDX_GEN_CTRL, 32'h4);
      rd(`IDX_GEN_CTRL, 32'h0);
    end
    wr(`IDX_GEN_CTRL, 32'h1);
    wr(`IDX_BRAKE_MODE, 32'hB0);
    fault <= 1'b1;
    n0 = falls;
    wt(40);
    rd(`IDX_GEN_CTRL, 32'h5);
    check({31'h0, falls != n0}, 32'h1);
    fault <= 1'b0;
    wr(`IDX_BRAKE_MODE, 32'h90);
    n0 = falls;
    wt(40);
    check({31'h0, falls != n0}, 32'h1);
    wr(`IDX_BRAKE_MODE, 32'h80);
    wr(`IDX_GEN_CTRL, 32'h0);
    wt(4);
    n0 = {10'h0, pwmOut};
    wr(`IDX_BRAKE_MODE, 32'h90);
    wt(4);
    check({26'h0, pwmOut}, 32'h2A);
    wr(`IDX_BRAKE_MODE, 32'h80);
    wt(4);
    check({26'h0, pwmOut}, {16'h0, n0});
    end_sim();
  end
endmodule
